/* File: rtl/scg_top.sv */
`timescale 1ns/1ps
`default_nettype none
module scg_top #(
	parameter int unsigned SLOW_DIV = scg_pkg::SLOW_DIV_DEFAULT
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic procWake,
	output scg_pkg::scg_gates_s gates,
	output logic [31:0] periphClkEn,
	output scg_pkg::scg_cfg_s cfg,
	output logic oscStable,
	output logic irq
);
	scg_pkg::scg_reg_e wrSel;
	scg_pkg::scg_reg_e rdSel;
	logic wrStrobe;
	logic rdSetup;
	logic [31:0] sysState;
	logic [31:0] sysStatus;
	logic [31:0] perState;
	logic [31:0] maskState;
	logic [31:0] ctrlStatus;
	logic [31:0] rdValue;
	logic [31:0] prdataReg;
	logic [31:0] osc_reg;
	logic [31:0] pllAReg;
	logic [31:0] pllBReg;
	logic [31:0] mckReg;
	logic [31:0] prog0Reg;
	logic [31:0] prog1Reg;
	logic [31:0] pumpReg;
	logic [31:0] evtReg;
	logic [31:0] evtSet;
	logic [31:0] wakeSet;
	logic [scg_pkg::SLOW_CNT_W-1:0] slowCntReg;
	logic slowTick;
	logic stablePrevReg;

	function automatic scg_pkg::scg_reg_e decode(input logic [7:0] a);
		scg_pkg::scg_reg_e r;
		r = scg_pkg::RG_NONE;
		if (a == scg_pkg::OFF_SYS_EN)
			r = scg_pkg::RG_SYS_EN;
		else if (a == scg_pkg::OFF_SYS_DIS)
			r = scg_pkg::RG_SYS_DIS;
		else if (a == scg_pkg::OFF_SYS_STAT)
			r = scg_pkg::RG_SYS_STAT;
		else if (a == scg_pkg::OFF_PER_EN)
			r = scg_pkg::RG_PER_EN;
		else if (a == scg_pkg::OFF_PER_DIS)
			r = scg_pkg::RG_PER_DIS;
		else if (a == scg_pkg::OFF_PER_STAT)
			r = scg_pkg::RG_PER_STAT;
		else if (a == scg_pkg::OFF_OSC)
			r = scg_pkg::RG_OSC;
		else if (a == scg_pkg::OFF_MFREQ)
			r = scg_pkg::RG_MFREQ;
		else if (a == scg_pkg::OFF_PLLA)
			r = scg_pkg::RG_PLLA;
		else if (a == scg_pkg::OFF_PLLB)
			r = scg_pkg::RG_PLLB;
		else if (a == scg_pkg::OFF_MCK)
			r = scg_pkg::RG_MCK;
		else if (a == scg_pkg::OFF_PROG0)
			r = scg_pkg::RG_PROG0;
		else if (a == scg_pkg::OFF_PROG1)
			r = scg_pkg::RG_PROG1;
		else if (a == scg_pkg::OFF_IRQ_EN)
			r = scg_pkg::RG_IRQ_EN;
		else if (a == scg_pkg::OFF_IRQ_DIS)
			r = scg_pkg::RG_IRQ_DIS;
		else if (a == scg_pkg::OFF_CTRL_STAT)
			r = scg_pkg::RG_CTRL_STAT;
		else if (a == scg_pkg::OFF_IRQ_MASK)
			r = scg_pkg::RG_IRQ_MASK;
		else if (a == scg_pkg::OFF_EVT)
			r = scg_pkg::RG_EVT;
		else if (a == scg_pkg::OFF_PUMP)
			r = scg_pkg::RG_PUMP;
		return r;
	endfunction

	// zero wait states: every access completes in its first access cycle
	assign pready = 1'b1;
	assign wrSel = decode(paddr);
	assign rdSel = wrSel;
	assign wrStrobe = psel && penable && pwrite && (wrSel != scg_pkg::RG_NONE);
	assign rdSetup = psel && !penable && !pwrite;
	assign pslverr = psel && penable && (wrSel == scg_pkg::RG_NONE);
	assign prdata = prdataReg;

	// slow clock stand-in: one-cycle enable from a divider
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
			slowCntReg <= '0;
		else if (slowCntReg == scg_pkg::SLOW_CNT_W'(SLOW_DIV - 1))
			slowCntReg <= '0;
		else
			slowCntReg <= scg_pkg::SLOW_CNT_W'(slowCntReg + 1'b1);
	end
	assign slowTick = (slowCntReg == scg_pkg::SLOW_CNT_W'(SLOW_DIV - 1));

	// only an interrupt-style wake restarts the processor clock
	assign wakeSet = {31'h0000_0000, procWake};

	scg_gate_bank #(
		.SET_MASK(scg_pkg::SYS_EN_MASK),
		.CLR_MASK(scg_pkg::SYS_DIS_MASK),
		.RST_VAL(scg_pkg::SYS_GATE_RST)
	) u_sys_gates (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.setWr(wrStrobe && wrSel == scg_pkg::RG_SYS_EN),
		.clrWr(wrStrobe && wrSel == scg_pkg::RG_SYS_DIS),
		.wdata(pwdata),
		.hwSet(wakeSet),
		.state(sysState)
	);

	scg_gate_bank #(
		.SET_MASK(scg_pkg::PER_MASK),
		.CLR_MASK(scg_pkg::PER_MASK),
		.RST_VAL(scg_pkg::PER_RST)
	) u_per_gates (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.setWr(wrStrobe && wrSel == scg_pkg::RG_PER_EN),
		.clrWr(wrStrobe && wrSel == scg_pkg::RG_PER_DIS),
		.wdata(pwdata),
		.hwSet(32'h0000_0000),
		.state(perState)
	);

	scg_gate_bank #(
		.SET_MASK(scg_pkg::EVT_MASK),
		.CLR_MASK(scg_pkg::EVT_MASK),
		.RST_VAL(32'h0000_0000)
	) u_irq_mask (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.setWr(wrStrobe && wrSel == scg_pkg::RG_IRQ_EN),
		.clrWr(wrStrobe && wrSel == scg_pkg::RG_IRQ_DIS),
		.wdata(pwdata),
		.hwSet(32'h0000_0000),
		.state(maskState)
	);

	scg_osc_timer u_osc (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.slowTick(slowTick),
		.oscEn(osc_reg[scg_pkg::OSC_EN_BIT]),
		.oscByp(osc_reg[scg_pkg::OSC_BYP_BIT]),
		.startCount(osc_reg[scg_pkg::OSC_CNT_LSB +: 8]),
		.stable(oscStable)
	);

	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
			osc_reg <= scg_pkg::OSC_RST;
		else if (wrStrobe && wrSel == scg_pkg::RG_OSC)
			osc_reg <= pwdata & scg_pkg::OSC_MASK;
	end

	// clock generator settings are only stored and passed on here
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			pllAReg <= scg_pkg::PLL_RST;
			pllBReg <= scg_pkg::PLL_RST;
			mckReg <= scg_pkg::MCK_RST;
			prog0Reg <= scg_pkg::PROG_RST;
			prog1Reg <= scg_pkg::PROG_RST;
			pumpReg <= scg_pkg::PUMP_RST;
		end
		else if (wrStrobe)
		begin
			if (wrSel == scg_pkg::RG_PLLA)
				pllAReg <= pwdata;
			if (wrSel == scg_pkg::RG_PLLB)
				pllBReg <= pwdata;
			if (wrSel == scg_pkg::RG_MCK)
				mckReg <= pwdata;
			if (wrSel == scg_pkg::RG_PROG0)
				prog0Reg <= pwdata;
			if (wrSel == scg_pkg::RG_PROG1)
				prog1Reg <= pwdata;
			if (wrSel == scg_pkg::RG_PUMP)
				pumpReg <= pwdata;
		end
	end

	// sticky event on each rise of the stable flag
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
			stablePrevReg <= 1'b0;
		else
			stablePrevReg <= oscStable;
	end
	assign evtSet = {31'h0000_0000, oscStable && !stablePrevReg};

	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
			evtReg <= 32'h0000_0000;
		else if (wrStrobe && wrSel == scg_pkg::RG_EVT)
			evtReg <= ((evtReg & ~pwdata) | evtSet) & scg_pkg::EVT_MASK;
		else
			evtReg <= (evtReg | evtSet) & scg_pkg::EVT_MASK;
	end
	assign irq = |(evtReg & maskState);

	// bit 1 of system status has no gate behind it and reads one
	assign sysStatus = sysState | scg_pkg::SYS_FIXED;
	assign ctrlStatus = scg_pkg::CTRL_FIXED
		| (32'(oscStable) << scg_pkg::CTRL_STABLE_BIT);

	// write-only registers read as zero
	always_comb
	begin
		rdValue = 32'h0000_0000;
		case (rdSel)
			scg_pkg::RG_SYS_STAT: rdValue = sysStatus;
			scg_pkg::RG_PER_STAT: rdValue = perState;
			scg_pkg::RG_OSC: rdValue = osc_reg;
			scg_pkg::RG_PLLA: rdValue = pllAReg;
			scg_pkg::RG_PLLB: rdValue = pllBReg;
			scg_pkg::RG_MCK: rdValue = mckReg;
			scg_pkg::RG_PROG0: rdValue = prog0Reg;
			scg_pkg::RG_PROG1: rdValue = prog1Reg;
			scg_pkg::RG_CTRL_STAT: rdValue = ctrlStatus;
			scg_pkg::RG_IRQ_MASK: rdValue = maskState;
			scg_pkg::RG_EVT: rdValue = evtReg;
			default: rdValue = 32'h0000_0000;
		endcase
	end

	// read data captured in setup, stable through the access cycle
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
			prdataReg <= 32'h0000_0000;
		else if (rdSetup)
			prdataReg <= rdValue;
	end

	assign gates.proc = sysState[scg_pkg::SYS_PROC_BIT];
	assign gates.usbHost = sysState[scg_pkg::SYS_HOST_BIT];
	assign gates.usbDev = sysState[scg_pkg::SYS_DEV_BIT];
	assign gates.progOut = sysState[scg_pkg::SYS_PROG_LSB +: 4];
	assign gates.aux = sysState[scg_pkg::SYS_AUX_LSB +: 2];
	assign periphClkEn = perState;
	assign cfg.pllA = pllAReg;
	assign cfg.pllB = pllBReg;
	assign cfg.masterClk = mckReg;
	assign cfg.progClk0 = prog0Reg;
	assign cfg.progClk1 = prog1Reg;
	assign cfg.chargePump = pumpReg;
	assign cfg.oscEnable = osc_reg[scg_pkg::OSC_EN_BIT];
	assign cfg.oscillator_bypass = osc_reg[scg_pkg::OSC_BYP_BIT];

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	property p_usb_on;
		wrStrobe && wrSel == scg_pkg::RG_SYS_EN && pwdata[7]
			|=> gates.usbDev && sysStatus[7];
	endproperty
	a_usb_on: assert property (p_usb_on)
		else $error("usb device clock not enabled");

	property p_usb_off;
		wrStrobe && wrSel == scg_pkg::RG_SYS_DIS && pwdata[7]
			|=> !gates.usbDev && !sysStatus[7];
	endproperty
	a_usb_off: assert property (p_usb_off)
		else $error("usb device clock not disabled");

	property p_prog_on;
		wrStrobe && wrSel == scg_pkg::RG_SYS_EN
			|=> (gates.progOut & $past(pwdata[11:8])) == $past(pwdata[11:8])
			&& sysStatus[11:8] == gates.progOut;
	endproperty
	a_prog_on: assert property (p_prog_on)
		else $error("programmable output not enabled");

	property p_prog_off;
		wrStrobe && wrSel == scg_pkg::RG_SYS_DIS
			|=> gates.progOut == ($past(gates.progOut) & ~$past(pwdata[11:8]));
	endproperty
	a_prog_off: assert property (p_prog_off)
		else $error("programmable output disable wrong");

	property p_proc_stop;
		wrStrobe && wrSel == scg_pkg::RG_SYS_DIS && pwdata[0] && !procWake
			|=> !gates.proc ##0 !sysStatus[0];
	endproperty
	a_proc_stop: assert property (p_proc_stop)
		else $error("processor clock did not stop");

	property p_status_read;
		rdSetup && rdSel == scg_pkg::RG_SYS_STAT
			|=> prdata == ($past(sysState) | scg_pkg::SYS_FIXED);
	endproperty
	a_status_read: assert property (p_status_read)
		else $error("system status read mismatch");

	property p_per_on;
		wrStrobe && wrSel == scg_pkg::RG_PER_EN
			|=> perState == ($past(perState) | ($past(pwdata) & scg_pkg::PER_MASK));
	endproperty
	a_per_on: assert property (p_per_on)
		else $error("peripheral enable wrong");

	property p_per_off;
		wrStrobe && wrSel == scg_pkg::RG_PER_DIS
			|=> perState == ($past(perState) & ~$past(pwdata));
	endproperty
	a_per_off: assert property (p_per_off)
		else $error("peripheral disable wrong");

	property p_unimpl;
		periphClkEn[1:0] == 2'b00;
	endproperty
	a_unimpl: assert property (p_unimpl)
		else $error("non-peripheral bits set");

	property p_reset_vals;
		$rose(rst_n) |-> sysStatus == scg_pkg::SYS_STAT_RST && perState == 32'h0;
	endproperty
	a_reset_vals: assert property (p_reset_vals)
		else $error("reset status values wrong");

	property p_bypass;
		$rose(osc_reg[scg_pkg::OSC_BYP_BIT]) |=> oscStable;
	endproperty
	a_bypass: assert property (p_bypass)
		else $error("bypass did not set stable flag");

	property p_osc_clear;
		!osc_reg[scg_pkg::OSC_EN_BIT] && !osc_reg[scg_pkg::OSC_BYP_BIT]
			|=> !oscStable;
	endproperty
	a_osc_clear: assert property (p_osc_clear)
		else $error("stable flag not cleared");

	property p_osc_layout;
		wrStrobe && wrSel == scg_pkg::RG_OSC
			|=> cfg.oscEnable == $past(pwdata[0])
			&& cfg.oscillator_bypass == $past(pwdata[1])
			&& osc_reg[15:8] == $past(pwdata[15:8]);
	endproperty
	a_osc_layout: assert property (p_osc_layout)
		else $error("oscillator register layout wrong");

	property p_host_aux;
		wrStrobe && wrSel == scg_pkg::RG_SYS_EN && pwdata[6] && pwdata[16]
			|=> gates.usbHost && gates.aux[0];
	endproperty
	a_host_aux: assert property (p_host_aux)
		else $error("host or aux gate not enabled");

	c_usb_on: cover property (wrStrobe && wrSel == scg_pkg::RG_SYS_EN
		&& pwdata[7]);
	c_proc_idle: cover property ($fell(gates.proc));
	c_osc_stable: cover property ($rose(oscStable) && !cfg.oscillator_bypass);
	c_irq: cover property ($rose(irq));
endmodule
`default_nettype wire

/* File: include/scg_pkg.sv */
// Functional notes
// - usb device enable bit turns 48M clock on
// - usb device disable bit turns clock off
// - enable bits 8-11 switch programmable outputs on
// - disable bits 8-11 switch programmable outputs off
// - disable bit 0 stops processor clock, idle
// - status bit 0 shows processor clock running
// - status bit 7 shows usb device clock
// - status bits 8-11 show programmable outputs
// - peripheral enable bits 2-31 start clocks
// - peripheral disable bits 2-31 stop clocks
// - peripheral status shows each clock, bits 0-1 none
// - unimplemented peripheral bits change nothing
// - reset: system status 0x03, peripheral 0x0
// - stable flag: startup, bypass at once, cleared
// - startup time is count times 8 slow cycles
package scg_pkg;
	localparam int unsigned ADDR_W = 8;
	localparam logic [7:0] OFF_SYS_EN = 8'h00;
	localparam logic [7:0] OFF_SYS_DIS = 8'h04;
	localparam logic [7:0] OFF_SYS_STAT = 8'h08;
	localparam logic [7:0] OFF_PER_EN = 8'h10;
	localparam logic [7:0] OFF_PER_DIS = 8'h14;
	localparam logic [7:0] OFF_PER_STAT = 8'h18;
	localparam logic [7:0] OFF_OSC = 8'h20;
	localparam logic [7:0] OFF_MFREQ = 8'h24;
	localparam logic [7:0] OFF_PLLA = 8'h28;
	localparam logic [7:0] OFF_PLLB = 8'h2c;
	localparam logic [7:0] OFF_MCK = 8'h30;
	localparam logic [7:0] OFF_PROG0 = 8'h40;
	localparam logic [7:0] OFF_PROG1 = 8'h44;
	localparam logic [7:0] OFF_IRQ_EN = 8'h60;
	localparam logic [7:0] OFF_IRQ_DIS = 8'h64;
	localparam logic [7:0] OFF_CTRL_STAT = 8'h68;
	localparam logic [7:0] OFF_IRQ_MASK = 8'h6c;
	localparam logic [7:0] OFF_EVT = 8'h70;
	localparam logic [7:0] OFF_PUMP = 8'h80;
	localparam int unsigned SYS_PROC_BIT = 0;
	localparam int unsigned SYS_HOST_BIT = 6;
	localparam int unsigned SYS_DEV_BIT = 7;
	localparam int unsigned SYS_PROG_LSB = 8;
	localparam int unsigned SYS_AUX_LSB = 16;
	localparam logic [31:0] SYS_EN_MASK = 32'h0003_0fc0;
	localparam logic [31:0] SYS_DIS_MASK = 32'h0003_0fc1;
	localparam logic [31:0] SYS_GATE_RST = 32'h0000_0001;
	localparam logic [31:0] SYS_FIXED = 32'h0000_0002;
	localparam logic [31:0] SYS_STAT_RST = 32'h0000_0003;
	localparam logic [31:0] PER_MASK = 32'hffff_fffc;
	localparam logic [31:0] PER_RST = 32'h0000_0000;
	localparam int unsigned OSC_EN_BIT = 0;
	localparam int unsigned OSC_BYP_BIT = 1;
	localparam int unsigned OSC_CNT_LSB = 8;
	localparam logic [31:0] OSC_MASK = 32'h0000_ff03;
	localparam logic [31:0] OSC_RST = 32'h0000_0000;
	localparam int unsigned OSC_CNT_SHIFT = 3;
	localparam logic [31:0] PLL_RST = 32'h0000_3f00;
	localparam logic [31:0] MCK_RST = 32'h0000_0000;
	localparam logic [31:0] PROG_RST = 32'h0000_0000;
	localparam logic [31:0] PUMP_RST = 32'h0000_0000;
	localparam logic [31:0] CTRL_FIXED = 32'h0000_0008;
	localparam int unsigned CTRL_STABLE_BIT = 0;
	localparam logic [31:0] EVT_MASK = 32'h0000_0001;
	localparam int unsigned EVT_STABLE_BIT = 0;
	localparam int unsigned CLK_HZ = 200_000_000;
	localparam int unsigned SLOW_HZ = 32_768;
	localparam int unsigned SLOW_DIV_DEFAULT = CLK_HZ / SLOW_HZ;
	localparam int unsigned SLOW_CNT_W = 16;

	typedef enum {
		RG_SYS_EN, RG_SYS_DIS, RG_SYS_STAT, RG_PER_EN, RG_PER_DIS,
		RG_PER_STAT, RG_OSC, RG_MFREQ, RG_PLLA, RG_PLLB, RG_MCK,
		RG_PROG0, RG_PROG1, RG_IRQ_EN, RG_IRQ_DIS, RG_CTRL_STAT,
		RG_IRQ_MASK, RG_EVT, RG_PUMP, RG_NONE
	} scg_reg_e;

	typedef struct packed {
		logic [1:0] aux;
		logic [3:0] progOut;
		logic usbDev;
		logic usbHost;
		logic proc;
	} scg_gates_s;

	typedef struct packed {
		logic [31:0] pllA;
		logic [31:0] pllB;
		logic [31:0] masterClk;
		logic [31:0] progClk0;
		logic [31:0] progClk1;
		logic [31:0] chargePump;
		logic oscEnable;
		logic oscillator_bypass;
	} scg_cfg_s;
endpackage

/* File: rtl/scg_gate_bank.sv */
`timescale 1ns/1ps
`default_nettype none
module scg_gate_bank #(
	parameter logic [31:0] SET_MASK = 32'h0000_0000,
	parameter logic [31:0] CLR_MASK = 32'h0000_0000,
	parameter logic [31:0] RST_VAL = 32'h0000_0000
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic setWr,
	input wire logic clrWr,
	input wire logic [31:0] wdata,
	input wire logic [31:0] hwSet,
	output logic [31:0] state
);
	logic [31:0] setBits;
	logic [31:0] clrBits;

	// zero bits and bits outside the masks leave the state alone
	assign setBits = setWr ? (wdata & SET_MASK) : 32'h0000_0000;
	assign clrBits = clrWr ? (wdata & CLR_MASK) : 32'h0000_0000;

	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
			state <= RST_VAL;
		else
			// set wins so a hardware event is never lost to a clear
			state <= (state & ~clrBits) | setBits
				| (hwSet & (SET_MASK | CLR_MASK));
	end
endmodule
`default_nettype wire

/* File: rtl/scg_osc_timer.sv */
`timescale 1ns/1ps
`default_nettype none
module scg_osc_timer (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic slowTick,
	input wire logic oscEn,
	input wire logic oscByp,
	input wire logic [7:0] startCount,
	output logic stable
);
	logic [10:0] elapsedReg;
	logic [10:0] elapsedNext;
	logic [10:0] target;

	assign target = {startCount, 3'b000};
	assign elapsedNext = 11'(elapsedReg + 11'h001);

	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			elapsedReg <= 11'h000;
			stable <= 1'b0;
		end
		else if (!oscEn && !oscByp)
		begin
			elapsedReg <= 11'h000;
			stable <= 1'b0;
		end
		else if (oscByp)
			stable <= 1'b1;
		else if (!stable && slowTick)
		begin
			// a count change mid start-up takes effect on the next tick
			elapsedReg <= elapsedNext;
			if (elapsedNext >= target)
				stable <= 1'b1;
		end
	end

	property p_startup_time;
		@(posedge ref_clk) disable iff (!rst_n)
		$rose(stable) && !$past(oscByp) |->
			$past(elapsedReg) + 11'h001 >= $past(target);
	endproperty
	a_startup_time: assert property (p_startup_time)
		else $error("oscillator stable before start-up time");
endmodule
`default_nettype wire

/* File: bench/scg_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module scg_tb_top;
	logic ref_clk, rst_n, psel, penable, pwrite, procWake;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, periphClkEn, sysExp, rd;
	logic pready, pslverr, oscStable, irq, er;
	scg_pkg::scg_gates_s gates;
	scg_pkg::scg_cfg_s cfg;
	int mismatches, comparisons, cycles;

	// slow tick shortened so the oscillator start-up fits a short run
	scg_top #(.SLOW_DIV(4)) u_scg_top (
		.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .procWake(procWake),
		.gates(gates), .periphClkEn(periphClkEn), .cfg(cfg),
		.oscStable(oscStable), .irq(irq)
	);

	always #2.5 ref_clk = ~ref_clk;

	task automatic end_of_test();
		if (mismatches == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// hang guard, far above the few hundred cycles the run needs
	always @(posedge ref_clk)
	begin
		cycles = cycles + 1;
		if (cycles == 20000)
		begin
			mismatches++;
			$display("BAD %0t timeout", $time);
			end_of_test();
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// one apb transfer; request held until pready sampled high
	task automatic xfer(input logic [7:0] a, input logic w,
		input logic [31:0] d);
		@(posedge ref_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		do
			@(posedge ref_clk);
		while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(a, 1'b1, d);
	endtask

	task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
		xfer(a, 1'b0, 32'h0000_0000);
		check(rd, exp);
	endtask

	// gate outputs settle one cycle after the access edge
	task automatic chkGates(input logic [31:0] e);
		@(negedge ref_clk);
		check({23'h0, gates}, {23'h0, e[17:16], e[11:8], e[7], e[6], e[0]});
	endtask

	task automatic reset_values();
		rdChk(scg_pkg::OFF_SYS_STAT, 32'h0000_0003);
		rdChk(scg_pkg::OFF_PER_STAT, 32'h0000_0000);
		rdChk(scg_pkg::OFF_OSC, 32'h0000_0000);
		rdChk(scg_pkg::OFF_PLLA, 32'h0000_3f00);
		rdChk(scg_pkg::OFF_PLLB, 32'h0000_3f00);
		rdChk(scg_pkg::OFF_MCK, 32'h0000_0000);
		rdChk(scg_pkg::OFF_CTRL_STAT, 32'h0000_0008);
		rdChk(scg_pkg::OFF_IRQ_MASK, 32'h0000_0000);
		chkGates(32'h0000_0001);
		check(periphClkEn, 32'h0000_0000);
		check({31'h0, irq}, 32'h0000_0000);
	endtask

	task automatic sys_gates();
		int bl[8] = '{6, 7, 8, 9, 10, 11, 16, 17};
		sysExp = 32'h0000_0003;
		wr(scg_pkg::OFF_SYS_EN, 32'hffff_ffff);
		sysExp = sysExp | 32'h0003_0fc0;
		rdChk(scg_pkg::OFF_SYS_STAT, sysExp);
		chkGates(sysExp);
		// disable one gate at a time, neighbours must stay on
		for (int i = 0; i < 8; i++)
		begin
			wr(scg_pkg::OFF_SYS_DIS, 32'h0000_0001 << bl[i]);
			sysExp[bl[i]] = 1'b0;
			rdChk(scg_pkg::OFF_SYS_STAT, sysExp);
			chkGates(sysExp);
		end
		wr(scg_pkg::OFF_SYS_EN, 32'h0000_0580);
		sysExp = sysExp | 32'h0000_0580;
		rdChk(scg_pkg::OFF_SYS_STAT, sysExp);
		wr(scg_pkg::OFF_SYS_DIS, 32'h0000_0000);
		rdChk(scg_pkg::OFF_SYS_STAT, sysExp);
		chkGates(sysExp);
	endtask

	task automatic proc_clock();
		wr(scg_pkg::OFF_SYS_DIS, 32'h0000_0001);
		sysExp[0] = 1'b0;
		rdChk(scg_pkg::OFF_SYS_STAT, sysExp);
		chkGates(sysExp);
		// the enable register carries no processor bit
		wr(scg_pkg::OFF_SYS_EN, 32'h0000_0001);
		rdChk(scg_pkg::OFF_SYS_STAT, sysExp);
		@(posedge ref_clk);
		procWake <= 1'b1;
		@(posedge ref_clk);
		procWake <= 1'b0;
		sysExp[0] = 1'b1;
		rdChk(scg_pkg::OFF_SYS_STAT, sysExp);
		chkGates(sysExp);
	endtask

	task automatic periph();
		wr(scg_pkg::OFF_PER_EN, 32'hffff_ffff);
		rdChk(scg_pkg::OFF_PER_STAT, 32'hffff_fffc);
		check(periphClkEn, 32'hffff_fffc);
		wr(scg_pkg::OFF_PER_DIS, 32'haaaa_aaab);
		rdChk(scg_pkg::OFF_PER_STAT, 32'h5555_5554);
		wr(scg_pkg::OFF_PER_EN, 32'h0000_0003);
		rdChk(scg_pkg::OFF_PER_STAT, 32'h5555_5554);
		wr(scg_pkg::OFF_PER_EN, 32'h0000_0008);
		rdChk(scg_pkg::OFF_PER_STAT, 32'h5555_555c);
		wr(scg_pkg::OFF_PER_DIS, 32'hffff_ffff);
		rdChk(scg_pkg::OFF_PER_STAT, 32'h0000_0000);
		check(periphClkEn, 32'h0000_0000);
	endtask

	task automatic access_kinds();
		rdChk(scg_pkg::OFF_SYS_EN, 32'h0000_0000);
		rdChk(scg_pkg::OFF_PER_DIS, 32'h0000_0000);
		wr(scg_pkg::OFF_SYS_STAT, 32'h0000_0000);
		rdChk(scg_pkg::OFF_SYS_STAT, sysExp);
		wr(scg_pkg::OFF_PLLA, 32'h2012_3456);
		rdChk(scg_pkg::OFF_PLLA, 32'h2012_3456);
		check({31'h0, er}, 32'h0000_0000);
		check(cfg.pllA, 32'h2012_3456);
		wr(scg_pkg::OFF_MCK, 32'h0000_0011);
		rdChk(scg_pkg::OFF_MCK, 32'h0000_0011);
		check(cfg.masterClk, 32'h0000_0011);
		wr(scg_pkg::OFF_PROG1, 32'h0000_0015);
		rdChk(scg_pkg::OFF_PROG1, 32'h0000_0015);
		check(cfg.progClk1, 32'h0000_0015);
		// charge pump setting is write-only and reads back zero
		wr(scg_pkg::OFF_PUMP, 32'h0000_0005);
		rdChk(scg_pkg::OFF_PUMP, 32'h0000_0000);
		check(cfg.chargePump, 32'h0000_0005);
		rdChk(8'h0c, 32'h0000_0000);
		check({31'h0, er}, 32'h0000_0001);
		xfer(8'h0c, 1'b1, 32'hffff_ffff);
		check({31'h0, er}, 32'h0000_0001);
		rdChk(scg_pkg::OFF_SYS_STAT, sysExp);
	endtask

	task automatic osc_and_irq();
		int n;
		// start-up count 2: 16 slow ticks of 4 cycles each
		wr(scg_pkg::OFF_OSC, 32'h0000_0201);
		n = 0;
		while (oscStable !== 1'b1 && n < 200)
		begin
			@(posedge ref_clk);
			n++;
		end
		check({31'h0, n >= 56 && n <= 72}, 32'h0000_0001);
		rdChk(scg_pkg::OFF_OSC, 32'h0000_0201);
		check({31'h0, cfg.oscEnable}, 32'h0000_0001);
		rdChk(scg_pkg::OFF_CTRL_STAT, 32'h0000_0009);
		rdChk(scg_pkg::OFF_EVT, 32'h0000_0001);
		check({31'h0, irq}, 32'h0000_0000);
		wr(scg_pkg::OFF_IRQ_EN, 32'h0000_0001);
		rdChk(scg_pkg::OFF_IRQ_MASK, 32'h0000_0001);
		check({31'h0, irq}, 32'h0000_0001);
		wr(scg_pkg::OFF_IRQ_DIS, 32'h0000_0001);
		@(negedge ref_clk);
		check({31'h0, irq}, 32'h0000_0000);
		wr(scg_pkg::OFF_IRQ_EN, 32'h0000_0001);
		wr(scg_pkg::OFF_EVT, 32'h0000_0001);
		rdChk(scg_pkg::OFF_EVT, 32'h0000_0000);
		check({31'h0, irq}, 32'h0000_0000);
		wr(scg_pkg::OFF_OSC, 32'h0000_ff00);
		repeat (2) @(negedge ref_clk);
		check({31'h0, oscStable}, 32'h0000_0000);
		// bypass needs no start-up wait despite the large count
		wr(scg_pkg::OFF_OSC, 32'h0000_ff02);
		repeat (2) @(negedge ref_clk);
		check({31'h0, oscStable}, 32'h0000_0001);
		rdChk(scg_pkg::OFF_OSC, 32'h0000_ff02);
		check({31'h0, cfg.oscillator_bypass}, 32'h0000_0001);
		wr(scg_pkg::OFF_OSC, 32'h0000_0000);
		repeat (2) @(negedge ref_clk);
		check({31'h0, oscStable}, 32'h0000_0000);
	endtask

	initial
	begin
		ref_clk = 1'b0;
		rst_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		procWake = 1'b0;
		mismatches = 0;
		comparisons = 0;
		cycles = 0;
		repeat (8) @(posedge ref_clk);
		rst_n <= 1'b1;
		reset_values();
		sys_gates();
		proc_clock();
		periph();
		access_kinds();
		osc_and_irq();
		repeat (4) @(posedge ref_clk);
		end_of_test();
	end
endmodule
`default_nettype wire
